// ===== vcs_pkg.sv
package vcs_pkg;

    // Word lengths on the serial line, in data clock cycles.
    localparam logic [4:0] VCS_COMP_BITS = 5'h08;
    localparam logic [4:0] VCS_LIN_BITS = 5'h10;

    // Width of the linear sample field and of the attenuation field.
    localparam int VCS_SAMPLE_W = 13;
    localparam int VCS_ATTEN_W = 3;

    // Attenuation step per code count, in dB.
    localparam logic [4:0] VCS_ATTEN_STEP_DB = 5'h03;

    // Master clocks per frame sync that the driving side must keep.
    localparam int VCS_MCLK_PER_FRAME = 256;

    // Sign-bit averager: accumulator width and leak shift.
    localparam int VCS_AZ_ACC_W = 16;
    localparam int VCS_AZ_SHIFT = 8;
    localparam int VCS_AZ_OUT_W = 8;

    // Positions of the pins inside the synchroniser vector.
    localparam int VCS_PIN_MCLK = 0;
    localparam int VCS_PIN_TXFS = 1;
    localparam int VCS_PIN_RXFS = 2;
    localparam int VCS_PIN_TXBC = 3;
    localparam int VCS_PIN_RXBC = 4;
    localparam int VCS_PIN_DIN = 5;
    localparam int VCS_PIN_LIN = 6;
    localparam int VCS_PIN_VAR = 7;
    localparam int VCS_PIN_MUTE = 8;
    localparam int VCS_PIN_COUNT = 9;

    // Values after reset.
    localparam logic [15:0] VCS_WORD_RST = 16'h0000;
    localparam logic [4:0] VCS_CNT_RST = 5'h00;
    localparam logic [12:0] VCS_SAMPLE_RST = 13'h0000;

    // Serial engine states, one-hot.
    typedef enum logic [1:0] {
        VCS_IDLE = 2'b01,
        VCS_SHIFT = 2'b10
    } vcs_state_t;

endpackage

// ===== vcs_sync.sv
// Two-stage synchroniser with a third stage kept for edge detection.
module vcs_sync
    import vcs_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] level_prev
);

    // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_level;
    logic [WIDTH-1:0] next_level_prev;

    // Next values of the three stages.
    always_comb
    begin
        next_meta = async_in;
        next_level = meta;
        next_level_prev = level;
    end

    // All stages clear under the synchronous reset.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta <= '0;
            level <= '0;
            level_prev <= '0;
        end
        else
        begin
            meta <= next_meta;
            level <= next_level;
            level_prev <= next_level_prev;
        end
    end

endmodule // vcs_sync

// ===== vcs_serial_port.sv
// Notes on behaviour
// [R1] Mute forces all-zero transmitted code.
// [R2] Sample from one frame leaves next frame.
// [R3] Average sign bit to cancel DC offset.
// [R4] Companded word: eight bits, sign first.
// [R5] Linear word: 13 sample bits, three trailing.
// [R6] Linear transmit: sign, sample, three zeros.
// [R7] Companded receive: first eight fixed, last eight variable.
// [R8] Linear receive sample from first 13 cycles.
// [R9] Attenuation code MSB first, 3 dB steps.
// [R10] Attenuation code never held between words.
// [R11] Sample bits first, then control bits.
// [R12] Code 000 loudest, 111 quietest.
// [R13] Master clock is 256 frame syncs.
// [R14] Frame rate at most 16 kHz.
// [R15] Fixed rate: tx rising, rx falling master.
// [R16] Variable rate: rx falling, tx rising bit clocks.
// [R17] Variable rate repeats transmit word while framed.
// [R18] Linear sample is two's complement.
// [R19] Attenuation applies to the carrying word.
module vcs_serial_port
    import vcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic master_clock,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    input wire logic tx_bit_clock,
    input wire logic rx_bit_clock,
    input wire logic rx_serial_in,
    input wire logic linear_mode_sel,
    input wire logic variable_rate_sel,
    input wire logic mic_silence_in,
    input wire logic [12:0] enc_sample,
    input wire logic enc_sample_valid,
    output logic tx_serial_out,
    output logic tx_serial_oe,
    output logic [12:0] rx_sample,
    output logic [2:0] rx_atten_code,
    output logic [4:0] rx_atten_db,
    output logic rx_word_strobe,
    output logic [7:0] autozero_offset
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection.

    // Every pin passes two flip-flops before anything here looks at it.
    logic [VCS_PIN_COUNT-1:0] pin_lvl;
    logic [VCS_PIN_COUNT-1:0] pin_prev;

    vcs_sync #(
        .WIDTH(VCS_PIN_COUNT)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({mic_silence_in, variable_rate_sel, linear_mode_sel, rx_serial_in,
            rx_bit_clock, tx_bit_clock, rx_frame_sync, tx_frame_sync, master_clock}),
        .level(pin_lvl),
        .level_prev(pin_prev)
    );

    logic lin;
    logic vrate;
    logic mute;
    logic din;
    logic txfs_rise;
    logic rxfs_rise;
    logic rxfs_fall;
    logic tclk_rise;
    logic rclk_fall;

    // Data and clocks share one synchroniser depth, so the sampled data bit
    // lines up with the detected clock edge exactly as on the pins.
    always_comb
    begin
        lin = pin_lvl[VCS_PIN_LIN];
        vrate = pin_lvl[VCS_PIN_VAR];
        mute = pin_lvl[VCS_PIN_MUTE];
        din = pin_lvl[VCS_PIN_DIN];
        txfs_rise = pin_lvl[VCS_PIN_TXFS] & ~pin_prev[VCS_PIN_TXFS];
        rxfs_rise = pin_lvl[VCS_PIN_RXFS] & ~pin_prev[VCS_PIN_RXFS];
        rxfs_fall = ~pin_lvl[VCS_PIN_RXFS] & pin_prev[VCS_PIN_RXFS];
        // Fixed rate clocks both directions from the master clock.
        if (vrate) // [R16]
        begin
            tclk_rise = pin_lvl[VCS_PIN_TXBC] & ~pin_prev[VCS_PIN_TXBC];
            rclk_fall = ~pin_lvl[VCS_PIN_RXBC] & pin_prev[VCS_PIN_RXBC]
                & pin_lvl[VCS_PIN_RXFS];
        end
        else // [R15]
        begin
            tclk_rise = pin_lvl[VCS_PIN_MCLK] & ~pin_prev[VCS_PIN_MCLK];
            rclk_fall = ~pin_lvl[VCS_PIN_MCLK] & pin_prev[VCS_PIN_MCLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path.

    vcs_state_t tx_state;
    vcs_state_t next_tx_state;
    logic [12:0] pending; // Sample taken in the current frame.
    logic [12:0] next_pending;
    logic [15:0] frame_word; // Formatted word for this frame, kept for repeats.
    logic [15:0] next_frame_word;
    logic [15:0] tx_shift; // Remaining bits, next bit at the top.
    logic [15:0] next_tx_shift;
    logic [4:0] tx_cnt; // Bits already sent of the current word.
    logic [4:0] next_tx_cnt;
    logic next_tx_out;
    logic next_tx_oe;
    logic [15:0] fmt_word;
    logic [15:0] src_word;
    logic [4:0] src_cnt;
    logic [4:0] tx_len;
    logic tx_live;

    // Loads the held sample at frame start and shifts on transmit clock edges.
    always_comb
    begin
        next_tx_state = tx_state;
        next_pending = enc_sample_valid ? enc_sample : pending;
        next_frame_word = frame_word;
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        // A held bit drops to zero as soon as mute is seen, not only at the next bit.
        next_tx_out = tx_serial_out & ~mute; // [R1]
        next_tx_oe = tx_serial_oe;
        tx_len = lin ? VCS_LIN_BITS : VCS_COMP_BITS;
        // Left-justify so the sign bit always leaves first.
        if (lin)
        begin
            fmt_word = {pending, 3'b000}; // [R5] [R6] [R18]
        end
        else
        begin
            fmt_word = {pending[7:0], 8'h00}; // [R4]
        end
        src_word = tx_shift;
        src_cnt = tx_cnt;
        tx_live = (tx_state == VCS_SHIFT);
        // Frame start takes last frame's sample into the shifter.
        if (txfs_rise) // [R2]
        begin
            next_frame_word = fmt_word;
            src_word = fmt_word;
            src_cnt = VCS_CNT_RST;
            tx_live = 1'b1;
            next_tx_state = VCS_SHIFT;
        end
        if (tx_live && tclk_rise)
        begin
            if (src_cnt == tx_len)
            begin
                // Another slot follows only in variable rate while framed.
                if (vrate && pin_lvl[VCS_PIN_TXFS]) // [R17]
                begin
                    next_tx_out = frame_word[15] & ~mute; // [R1]
                    next_tx_shift = {frame_word[14:0], 1'b0};
                    next_tx_cnt = 5'h01;
                end
                else
                begin
                    next_tx_oe = 1'b0;
                    next_tx_state = VCS_IDLE;
                end
            end
            else
            begin
                next_tx_out = src_word[15] & ~mute; // [R1] [R11]
                next_tx_oe = 1'b1;
                next_tx_shift = {src_word[14:0], 1'b0};
                next_tx_cnt = src_cnt + 5'h01;
            end
        end
        else if (txfs_rise)
        begin
            next_tx_shift = fmt_word;
            next_tx_cnt = VCS_CNT_RST;
        end
    end

    // Transmit registers; the line is released after reset.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            tx_state <= VCS_IDLE;
            pending <= VCS_SAMPLE_RST;
            frame_word <= VCS_WORD_RST;
            tx_shift <= VCS_WORD_RST;
            tx_cnt <= VCS_CNT_RST;
            tx_serial_out <= 1'b0;
            tx_serial_oe <= 1'b0;
        end
        else
        begin
            tx_state <= next_tx_state;
            pending <= next_pending;
            frame_word <= next_frame_word;
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            tx_serial_out <= next_tx_out;
            tx_serial_oe <= next_tx_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path.

    vcs_state_t rx_state;
    vcs_state_t next_rx_state;
    logic [15:0] rx_shift; // Newest bit enters at the bottom.
    logic [15:0] next_rx_shift;
    logic [4:0] rx_cnt;
    logic [4:0] next_rx_cnt;
    logic [12:0] next_rx_sample;
    logic [2:0] next_rx_atten_code;
    logic [4:0] next_rx_atten_db;
    logic next_rx_word_strobe;
    logic [15:0] shifted;
    logic last_eight;

    // Collects bits on receive clock edges and publishes a whole word.
    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_cnt = rx_cnt;
        next_rx_sample = rx_sample;
        next_rx_atten_code = rx_atten_code;
        next_rx_atten_db = rx_atten_db;
        next_rx_word_strobe = 1'b0;
        shifted = {rx_shift[14:0], din};
        // Variable-rate companded words are the last eight bits of the frame.
        last_eight = vrate & ~lin; // [R7]
        if (rxfs_rise)
        begin
            next_rx_state = VCS_SHIFT;
            next_rx_cnt = VCS_CNT_RST;
            next_rx_shift = VCS_WORD_RST;
        end
        else if (rx_state == VCS_SHIFT)
        begin
            if (rclk_fall)
            begin
                next_rx_shift = shifted;
                // Saturate so long variable-rate frames cannot wrap.
                if (rx_cnt != VCS_LIN_BITS)
                begin
                    next_rx_cnt = rx_cnt + 5'h01;
                end
                if (!last_eight && lin && rx_cnt == VCS_LIN_BITS - 5'h01)
                begin
                    // Sample first, then the code; a fresh code every word.
                    next_rx_sample = shifted[15:3]; // [R8] [R11] [R18]
                    next_rx_atten_code = shifted[2:0]; // [R9] [R10] [R19]
                    // Code 0 is full level, code 7 is 21 dB down.
                    next_rx_atten_db = 5'(shifted[2:0] * VCS_ATTEN_STEP_DB); // [R12]
                    next_rx_word_strobe = 1'b1;
                    next_rx_state = VCS_IDLE;
                end
                else if (!last_eight && !lin && rx_cnt == VCS_COMP_BITS - 5'h01)
                begin
                    next_rx_sample = {5'h00, shifted[7:0]}; // [R4] [R7]
                    next_rx_atten_code = 3'b000; // [R10]
                    next_rx_atten_db = 5'h00;
                    next_rx_word_strobe = 1'b1;
                    next_rx_state = VCS_IDLE;
                end
            end
            else if (rxfs_fall && vrate)
            begin
                // Frame closed: companded takes the last eight bits heard;
                // a short linear word is dropped.
                if (last_eight && rx_cnt >= VCS_COMP_BITS)
                begin
                    next_rx_sample = {5'h00, rx_shift[7:0]}; // [R7]
                    next_rx_atten_code = 3'b000;
                    next_rx_atten_db = 5'h00;
                    next_rx_word_strobe = 1'b1;
                end
                next_rx_state = VCS_IDLE;
            end
        end
    end

    // Receive registers.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            rx_state <= VCS_IDLE;
            rx_shift <= VCS_WORD_RST;
            rx_cnt <= VCS_CNT_RST;
            rx_sample <= VCS_SAMPLE_RST;
            rx_atten_code <= 3'b000;
            rx_atten_db <= 5'h00;
            rx_word_strobe <= 1'b0;
        end
        else
        begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_cnt <= next_rx_cnt;
            rx_sample <= next_rx_sample;
            rx_atten_code <= next_rx_atten_code;
            rx_atten_db <= next_rx_atten_db;
            rx_word_strobe <= next_rx_word_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Autozero sign-bit averager.

    // Leaky integrator: a step of 256 per sample toward the sign, minus a
    // fraction of itself. Long time constant trades settling for low ripple.
    logic signed [VCS_AZ_ACC_W-1:0] az_acc;
    logic signed [VCS_AZ_ACC_W-1:0] next_az_acc;
    logic [7:0] next_az_offset;
    logic enc_sign;

    always_comb
    begin
        enc_sign = lin ? enc_sample[12] : enc_sample[7];
        next_az_acc = az_acc;
        if (enc_sample_valid) // [R3]
        begin
            next_az_acc = az_acc + (enc_sign ? -16'sd256 : 16'sd256)
                - (az_acc >>> VCS_AZ_SHIFT);
        end
        // The offset to subtract is the averaged sign, scaled down.
        next_az_offset = az_acc[VCS_AZ_ACC_W-1 -: VCS_AZ_OUT_W]; // [R3]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            az_acc <= '0;
            autozero_offset <= 8'h00;
        end
        else
        begin
            az_acc <= next_az_acc;
            autozero_offset <= next_az_offset;
        end
    end

endmodule // vcs_serial_port

// ===== vcs_port_checker.sv
// Watches the serial port pins and the decoded receive outputs.
module vcs_port_checker
    import vcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    input wire logic linear_mode_sel,
    input wire logic variable_rate_sel,
    input wire logic mic_silence_in,
    input wire logic tx_serial_out,
    input wire logic tx_serial_oe,
    input wire logic [12:0] rx_sample,
    input wire logic [2:0] rx_atten_code,
    input wire logic [4:0] rx_atten_db,
    input wire logic rx_word_strobe
);
    // Windows in system clocks after a frame sync rise, for a 10:1 clock ratio.
    // Variable-rate frames hold their syncs for 16 slots, so they use the long windows.
    localparam int TX_LIN_MAX = 166;
    localparam int TX_CMP_MAX = 86;
    localparam int RX_LIN_LO = 154;
    localparam int RX_LIN_HI = 164;
    localparam int RX_CMP_LO = 74;
    localparam int RX_CMP_HI = 84;
    logic fsx_q; // Previous frame sync samples.
    logic fsr_q;
    logic [7:0] since_fsx; // Saturating ages of the last frame sync rises.
    logic [7:0] since_fsr;
    logic [7:0] next_since_fsx;
    logic [7:0] next_since_fsr;
    ////////////////////////////////////////////////////////////////////////////////
    // Ages restart on a rise and stop at the top so they never wrap into a window.
    always_comb
    begin
        next_since_fsx = (since_fsx == 8'hFF) ? since_fsx : since_fsx + 8'h01;
        next_since_fsr = (since_fsr == 8'hFF) ? since_fsr : since_fsr + 8'h01;
        if (tx_frame_sync && !fsx_q)
            next_since_fsx = 8'h00;
        if (rx_frame_sync && !fsr_q)
            next_since_fsr = 8'h00;
    end
    // Registers of the helper ages; reset parks them far outside every window.
    always_ff @(posedge sys_clk)
    begin
        fsx_q <= tx_frame_sync;
        fsr_q <= rx_frame_sync;
        since_fsx <= reset_n ? next_since_fsx : 8'hFF;
        since_fsr <= reset_n ? next_since_fsr : 8'hFF;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence muted_run;
        mic_silence_in [*5];
    endsequence
    sequence oe_soon;
        ##[2:6] tx_serial_oe;
    endsequence
    mute_zero_a: assert property (muted_run |-> !tx_serial_out)
        else $error("Muted transmit bit is not zero.");
    oe_start_a: assert property ($rose(tx_frame_sync) && !variable_rate_sel |-> oe_soon)
        else $error("Transmit did not start after frame sync.");
    oe_length_a: assert property (tx_serial_oe |->
        since_fsx <= (linear_mode_sel || variable_rate_sel ? TX_LIN_MAX : TX_CMP_MAX))
        else $error("Transmit word too long.");
    strobe_window_a: assert property (rx_word_strobe |->
        linear_mode_sel || variable_rate_sel ?
        (since_fsr >= RX_LIN_LO && since_fsr <= RX_LIN_HI) :
        (since_fsr >= RX_CMP_LO && since_fsr <= RX_CMP_HI)) else $error("Word strobe mistimed.");
    strobe_once_a: assert property (rx_word_strobe |=> !rx_word_strobe [*8])
        else $error("Word strobe repeated.");
    atten_db_a: assert property (rx_word_strobe |->
        rx_atten_db == {2'b00, rx_atten_code} * VCS_ATTEN_STEP_DB) else $error("Bad dB value.");
    comp_code_a: assert property (rx_word_strobe && !linear_mode_sel |->
        rx_atten_code == 3'h0 && rx_sample[12:8] == 5'h00) else $error("Companded fields wrong.");
    rx_hold_a: assert property (!rx_word_strobe |-> $stable(rx_atten_code) && $stable(rx_sample))
        else $error("Receive outputs moved without a word.");
endmodule // vcs_port_checker

bind vcs_serial_port vcs_port_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync),
    .linear_mode_sel(linear_mode_sel), .variable_rate_sel(variable_rate_sel),
    .mic_silence_in(mic_silence_in), .tx_serial_out(tx_serial_out),
    .tx_serial_oe(tx_serial_oe), .rx_sample(rx_sample), .rx_atten_code(rx_atten_code),
    .rx_atten_db(rx_atten_db), .rx_word_strobe(rx_word_strobe));

// ===== vcs_dsp_model.sv
// Behavioural signal processor on the far side of the serial port.
module vcs_dsp_model
(
    output logic master_clock,
    output logic tx_frame_sync,
    output logic rx_frame_sync,
    output logic tx_bit_clock,
    output logic rx_bit_clock,
    output logic rx_serial_in,
    input wire logic tx_serial_out,
    input wire logic linear_mode_sel,
    input wire logic variable_rate_sel,
    input wire logic [15:0] send_word,
    output logic [15:0] got_word,
    output int frames
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] slot; // Master clocks into the current frame.
    logic [4:0] bits; // Slots that the data spans in the selected mode; the syncs span them only in variable rate.
    logic lin_q; // Modes taken between frames, so no frame is cut by a mode change.
    logic var_q;
    // Variable rate holds the syncs for 16 slots: one linear or two companded words.
    assign bits = (lin_q || var_q) ? 5'h10 : 5'h08;
    // Bit clocks follow the master clock, which keeps them synchronous with it.
    assign tx_bit_clock = master_clock;
    assign rx_bit_clock = master_clock;
    ////////////////////////////////////////////////////////////////////////////////
    // A 4 MHz master clock keeps the frame rate within limit; the start offset
    // keeps its edges off the system clock edges.
    initial
    begin
        master_clock = 1'b0;
        tx_frame_sync = 1'b0;
        rx_frame_sync = 1'b0;
        rx_serial_in = 1'b0;
        got_word = 16'h0000;
        frames = 0;
        slot = 8'hF0;
        lin_q = 1'b0;
        var_q = 1'b0;
        #7;
        forever #125 master_clock = ~master_clock;
    end
    // Syncs, data and capture all move on the rising master clock edge.
    always @(posedge master_clock)
    begin
        tx_frame_sync <= var_q ? (slot < {3'h0, bits}) : (slot == 8'h00);
        rx_frame_sync <= var_q ? (slot < {3'h0, bits}) : (slot == 8'h00);
        if (slot < {3'h0, bits})
            rx_serial_in <= send_word[bits - 5'h01 - slot[4:0]];
        else
            rx_serial_in <= ~rx_serial_in; // Released line shows no stale value.
        if (slot >= 8'h01 && slot <= {3'h0, bits})
            got_word <= {got_word[14:0], tx_serial_out};
        if (slot == 8'hFF)
        begin
            lin_q <= linear_mode_sel;
            var_q <= variable_rate_sel;
        end
        if (slot == 8'h00)
            frames <= frames + 1;
        slot <= slot + 8'h01;
    end
endmodule // vcs_dsp_model

// ===== voice_codec_serial_word_port_tb.sv
// Frame-level bench: one sample out and one word in per frame.
module voice_codec_serial_word_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic linear_mode_sel = 1'b1;
    logic mic_silence_in = 1'b0;
    logic [12:0] enc_sample = 13'h0000;
    logic enc_sample_valid = 1'b0;
    logic [15:0] send_word = 16'h0000; // Word the far side sends.
    logic [15:0] got_word; // Word the far side caught.
    logic master_clock, tx_frame_sync, rx_frame_sync, rx_serial_in;
    logic tx_bit_clock, rx_bit_clock;
    logic variable_rate_sel = 1'b0;
    logic [7:0] autozero_offset;
    logic signed [15:0] az_exp = 16'sh0000; // Expected sign average, +-256 per sample.
    logic tx_serial_out, tx_serial_oe, rx_word_strobe;
    logic [12:0] rx_sample;
    logic [2:0] rx_atten_code;
    logic [4:0] rx_atten_db;
    int frames;
    int err_count = 0;
    int comparisons = 0;
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // The far side drives both fixed-rate and variable-rate timing.
    vcs_serial_port DUT (.sys_clk(sys_clk), .reset_n(reset_n), .master_clock(master_clock),
        .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync),
        .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
        .rx_serial_in(rx_serial_in), .linear_mode_sel(linear_mode_sel),
        .variable_rate_sel(variable_rate_sel), .mic_silence_in(mic_silence_in),
        .enc_sample(enc_sample), .enc_sample_valid(enc_sample_valid),
        .tx_serial_out(tx_serial_out), .tx_serial_oe(tx_serial_oe), .rx_sample(rx_sample),
        .rx_atten_code(rx_atten_code), .rx_atten_db(rx_atten_db),
        .rx_word_strobe(rx_word_strobe), .autozero_offset(autozero_offset));
    vcs_dsp_model u_dsp (.master_clock(master_clock), .tx_frame_sync(tx_frame_sync),
        .rx_frame_sync(rx_frame_sync), .tx_bit_clock(tx_bit_clock),
        .rx_bit_clock(rx_bit_clock), .rx_serial_in(rx_serial_in),
        .tx_serial_out(tx_serial_out), .linear_mode_sel(linear_mode_sel),
        .variable_rate_sel(variable_rate_sel), .send_word(send_word),
        .got_word(got_word), .frames(frames));
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops the run.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Compares one result word; four-state equality so unknowns fail.
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait: 0 for a new frame, 1 for the word strobe, 2 for the driver letting go.
    task automatic wait_for(input int what);
        int f0;
        int i;
        f0 = frames;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge sys_clk);
            #1;
            if ((what == 0 && frames != f0) || (what == 1 && rx_word_strobe === 1'b1)
                || (what == 2 && tx_serial_oe === 1'b0))
                return;
        end
        err_count++;
        results();
    endtask
    // Loads a sample for the next frame and a word to receive in it, then checks both.
    task automatic xfer(input logic lin, input logic vr, input logic mute,
        input logic [12:0] smp, input logic [15:0] rxw);
        logic [12:0] exp_smp;
        logic [2:0] exp_code;
        logic [15:0] exp_tx;
        exp_smp = lin ? rxw[15:3] : {5'h00, rxw[7:0]};
        exp_code = lin ? rxw[2:0] : 3'h0;
        // A variable-rate companded frame spans two slots, so the word goes out twice.
        exp_tx = mute ? 16'h0000 : (lin ? {smp, 3'h0} : (vr ? {2{smp[7:0]}} : {8'h00, smp[7:0]}));
        @(posedge sys_clk);
        linear_mode_sel <= lin;
        variable_rate_sel <= vr;
        mic_silence_in <= mute;
        send_word <= rxw;
        // Mode pins pass the synchroniser before the sample's sign is judged.
        repeat (4) @(posedge sys_clk);
        enc_sample <= smp;
        enc_sample_valid <= 1'b1;
        az_exp = az_exp + ((lin ? smp[12] : smp[7]) ? -16'sd256 : 16'sd256) - (az_exp >>> 8);
        @(posedge sys_clk);
        enc_sample_valid <= 1'b0;
        wait_for(0);
        wait_for(1);
        check_word({3'h0, rx_sample}, {3'h0, exp_smp});
        check_word({13'h0000, rx_atten_code}, {13'h0000, exp_code});
        check_word({11'h000, rx_atten_db}, {11'h000, {2'h0, exp_code} * 5'h03});
        wait_for(2);
        check_word((lin || vr) ? got_word : {8'h00, got_word[7:0]}, exp_tx);
        check_word({8'h00, autozero_offset}, {8'h00, az_exp[15:8]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Fixed-rate linear then companded words, the code changing every linear frame, then
    // variable-rate words; the last one takes two companded slots.
    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 13'h1A5C, 16'hC3F7);
        xfer(1'b1, 1'b0, 1'b0, 13'h0001, 16'h1230);
        xfer(1'b1, 1'b0, 1'b1, 13'h1FFF, 16'h8005);
        xfer(1'b0, 1'b0, 1'b0, 13'h0080, 16'h00A5);
        xfer(1'b0, 1'b0, 1'b0, 13'h007F, 16'h005A);
        xfer(1'b0, 1'b0, 1'b1, 13'h00FF, 16'h00FF);
        xfer(1'b1, 1'b1, 1'b0, 13'h0ABC, 16'h5556);
        xfer(1'b0, 1'b1, 1'b0, 13'h00C3, 16'h3CA5);
        results();
    end
endmodule // voice_codec_serial_word_port_tb
